// file: qsd_pkg.sv
package qsd_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DELAY  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RXMASK = 8'h0C;
	localparam logic [7:0] OFS_RXID   = 8'h10;
	localparam logic [7:0] OFS_INTERRUPT_MASK_REGISTER  = 8'h14;
	localparam logic [7:0] OFS_RXLO   = 8'h18;
	localparam logic [7:0] OFS_RXHI   = 8'h1C;
	localparam logic [7:0] OFS_QUEUE  = 8'h40;
	localparam logic [7:0] OFS_QEND   = 8'h7C;

	// control, status, delay and interrupt mask field positions
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_WRAP   = 1;
	localparam int CTRL_FINIE  = 2;
	localparam int ST_FIN      = 0;
	localparam int ST_BUSY     = 1;
	localparam int ST_CPTR_LSB = 4;
	localparam int ST_RXFULL   = 8;
	localparam int DLY_POST_LSB = 8;
	localparam int INTERRUPT_MASK_REGISTER_RX6   = 6;

	// reset values
	localparam logic [31:0] RST_RXMASK = 32'h0FF0FFFE;
	localparam logic [31:0] RST_RXID   = 32'h00000000;
	localparam logic [6:0]  RST_PRE    = 7'h16;
	localparam logic [7:0]  RST_POST   = 8'h08;

	// timing in system clocks
	localparam int           SCK_DIV     = 4;
	localparam int           WORD_BITS   = 16;
	localparam logic [5:0]   SHIFT_LAST  = 6'(SCK_DIV * WORD_BITS - 1);
	localparam int           POST_UNIT   = 32;
	localparam logic [12:0]  POST_MAX    = 13'(256 * POST_UNIT - 1);
	localparam logic [3:0]   QUEUE_LAST  = 4'hF;
	localparam int           QUEUE_DEPTH = 16;

	typedef enum logic [1:0] {
		QSD_IDLE,
		QSD_PRE,
		QSD_SHIFT,
		QSD_POST
	} qsd_seq_e;

endpackage

// file: qsd_rx_filter.sv
`timescale 1ns/1ps
module qsd_rx_filter
	import qsd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        frame_valid,
	input  wire logic [31:0] frame_id,
	input  wire logic [63:0] frame_data,
	input  wire logic [31:0] receive_global_mask,
	input  wire logic [31:0] match_id,
	output logic             hit,
	output logic [63:0]      hit_data
);

	typedef struct packed {
		logic        hit;
		logic [63:0] data;
	} qsd_flt_s;

	qsd_flt_s r_reg;
	qsd_flt_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.hit = 1'b0;
		// masked_id_bits are don't-care, so all audio ids share one buffer
		if (frame_valid && (((frame_id ^ match_id) & receive_global_mask) == 32'h0)) begin
			r_next.hit = 1'b1;
			r_next.data = frame_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hit = r_reg.hit;
	assign hit_data = r_reg.data;

endmodule

// file: qsd_shifter.sv
`timescale 1ns/1ps
module qsd_shifter
	import qsd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [15:0] word,
	output logic             sck,
	output logic             mosi,
	output logic             cs_n
);

	typedef struct packed {
		logic        busy;
		logic [5:0]  cnt;
		logic [15:0] sh;
		logic        sck;
		logic        mosi;
		logic        cs_n;
	} qsd_sh_s;

	qsd_sh_s r_reg;
	qsd_sh_s r_next;

	always_comb begin
		r_next = r_reg;
		if (start) begin
			r_next.busy = 1'b1;
			r_next.cnt = 6'h00;
			r_next.sh = word;
			r_next.mosi = word[15];
			r_next.sck = 1'b0;
			r_next.cs_n = 1'b0;
		end else if (r_reg.busy) begin
			if (r_reg.cnt == SHIFT_LAST) begin
				r_next.busy = 1'b0;
				r_next.sck = 1'b0;
				r_next.cs_n = 1'b1;
				r_next.mosi = 1'b0;
			end else begin
				r_next.cnt = r_reg.cnt + 6'h01;
				// sck is system clock / 4: two low, two high
				r_next.sck = r_next.cnt[1];
				if (r_reg.cnt[1:0] == 2'h3) begin
					r_next.sh = {r_reg.sh[14:0], 1'b0};
					r_next.mosi = r_reg.sh[14];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r_reg <= '{busy: 1'b0, cnt: 6'h00, sh: 16'h0000,
				sck: 1'b0, mosi: 1'b0, cs_n: 1'b1};
		end else begin
			r_reg <= r_next;
		end
	end

	assign sck = r_reg.sck;
	assign mosi = r_reg.mosi;
	assign cs_n = r_reg.cs_n;

endmodule

// file: qsd_audio_out.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module qsd_audio_out
	import qsd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        can_frame_valid,
	input  wire logic [31:0] can_frame_id,
	input  wire logic [63:0] can_frame_data,
	output logic             dac_sck,
	output logic             dac_mosi,
	output logic             dac_cs_n,
	output logic             dac_right,
	output logic             finished_irq,
	output logic             rx_irq
);

	////////////////////////////////////////////////////////////////////////
	// register map, byte offsets from the package
	//   ctrl    run, wrap, finished interrupt enable
	//   delay   pre delay [6:0], post delay in 32-clock units [15:8]
	//   status  finished (w1c), busy, completed_queue_pointer, rx full (w1c)
	//   rxmask  receive_global_mask, a zero bit ignores that id bit
	//   rxid    id that the unmasked bits must equal
	//   interrupt_mask_register   interrupt_mask_register, bit 6 gates rx_irq
	//   rxlo/hi payload bytes 0-3 and 4-7 of the last accepted frame
	//   queue   sixteen 8-bit samples, one per word
	// word timing is pre + 64 + post*32 clocks, 342 with reset values
	// delays are read when each count loads, so a change made mid-word
	// shows from the next load on and the queue need not be stopped

	typedef struct packed {
		logic                    wait_q;
		logic [31:0]             rdata;
		logic                    run;
		logic                    wrap;
		logic                    fin_ie;
		logic [6:0]              pre;
		logic [7:0]              post;
		logic [31:0]             rxmask;
		logic [31:0]             rxid;
		logic [31:0]             interrupt_mask_register;
		logic [63:0]             rxbuf;
		logic                    rxfull;
		logic                    fin;
		qsd_seq_e                state;
		logic [12:0]             cnt;
		logic [3:0]              ptr;
		logic [3:0]              cptr;
		logic                    right;
		logic                    fin_irq;
		logic                    rx_irq;
		logic [QUEUE_DEPTH-1:0][7:0] queue;
	} qsd_top_s;

	qsd_top_s r_reg;
	qsd_top_s r_next;

	logic        req;
	logic        hit;
	logic [63:0] hit_data;
	logic        shift_start;
	logic [31:0] rd_value;
	logic [31:0] status_word;

	assign req = avs_read | avs_write;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// 1..127, a zero field still gives one clock
	function automatic logic [12:0] pre_load(input logic [6:0] p);
		logic [12:0] res;
		res = (p == 7'h00) ? 13'h0000 : 13'({6'h00, p} - 13'h0001);
		return res;
	endfunction

	// field n means n*32 clocks, zero means 8192
	function automatic logic [12:0] post_load(input logic [7:0] p);
		logic [12:0] res;
		if (p == 8'h00) begin
			res = POST_MAX;
		end else begin
			res = 13'({p, 5'h00} - 13'h0001);
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sub blocks

	// filter output is registered: a frame lands two edges after its pulse
	qsd_rx_filter u_filter (
		.clock               (clock),
		.rst_n               (rst_n),
		.frame_valid         (can_frame_valid),
		.frame_id            (can_frame_id),
		.frame_data          (can_frame_data),
		.receive_global_mask (r_reg.rxmask),
		.match_id            (r_reg.rxid),
		.hit                 (hit),
		.hit_data            (hit_data)
	);

	// sample sits in the high byte, low byte zero
	// start goes with the last pre-delay cycle so both counters agree
	assign shift_start = (r_reg.state == QSD_PRE) && (r_reg.cnt == 13'h0000);

	qsd_shifter u_shifter (
		.clock (clock),
		.rst_n (rst_n),
		.start (shift_start),
		.word  ({r_reg.queue[r_reg.ptr], 8'h00}),
		.sck   (dac_sck),
		.mosi  (dac_mosi),
		.cs_n  (dac_cs_n)
	);

	////////////////////////////////////////////////////////////////////////
	// register read mux
	// reads have no side effects, so a repeated read is harmless

	always_comb begin
		status_word = 32'h0;
		status_word[ST_FIN] = r_reg.fin;
		status_word[ST_BUSY] = (r_reg.state != QSD_IDLE);
		status_word[ST_CPTR_LSB +: 4] = r_reg.cptr;
		status_word[ST_RXFULL] = r_reg.rxfull;
	end

	always_comb begin
		rd_value = 32'h0;
		if (avs_address == OFS_CTRL) begin
			rd_value[CTRL_RUN] = r_reg.run;
			rd_value[CTRL_WRAP] = r_reg.wrap;
			rd_value[CTRL_FINIE] = r_reg.fin_ie;
		end else if (avs_address == OFS_DELAY) begin
			rd_value[6:0] = r_reg.pre;
			rd_value[DLY_POST_LSB +: 8] = r_reg.post;
		end else if (avs_address == OFS_STATUS) begin
			rd_value = status_word;
		end else if (avs_address == OFS_RXMASK) begin
			rd_value = r_reg.rxmask;
		end else if (avs_address == OFS_RXID) begin
			rd_value = r_reg.rxid;
		end else if (avs_address == OFS_INTERRUPT_MASK_REGISTER) begin
			rd_value = r_reg.interrupt_mask_register;
		end else if (avs_address == OFS_RXLO) begin
			rd_value = r_reg.rxbuf[31:0];
		end else if (avs_address == OFS_RXHI) begin
			rd_value = r_reg.rxbuf[63:32];
		end else if ((avs_address >= OFS_QUEUE) && (avs_address <= OFS_QEND)
				&& (avs_address[1:0] == 2'h0)) begin
			rd_value[7:0] = r_reg.queue[avs_address[5:2]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] wv;
		wv = 32'h0;
		r_next = r_reg;

		// bus: one wait cycle, then the access completes
		// waitrequest comes from a flop, so every access takes two cycles
		if (req && r_reg.wait_q) begin
			r_next.wait_q = 1'b0;
			r_next.rdata = rd_value;
		end else begin
			r_next.wait_q = 1'b1;
		end

		if (avs_write && !r_reg.wait_q) begin
			if (avs_address == OFS_CTRL) begin
				wv = merge({29'h0, r_reg.fin_ie, r_reg.wrap, r_reg.run},
					avs_writedata, avs_byteenable);
				r_next.run = wv[CTRL_RUN];
				r_next.wrap = wv[CTRL_WRAP];
				r_next.fin_ie = wv[CTRL_FINIE];
			end else if (avs_address == OFS_DELAY) begin
				wv = merge({16'h0, r_reg.post, 1'b0, r_reg.pre},
					avs_writedata, avs_byteenable);
				r_next.pre = wv[6:0];
				r_next.post = wv[DLY_POST_LSB +: 8];
			end else if (avs_address == OFS_STATUS) begin
				// write one to clear; a set in the same cycle wins below
				if (avs_byteenable[0] && avs_writedata[ST_FIN]) begin
					r_next.fin = 1'b0;
				end
				if (avs_byteenable[1] && avs_writedata[ST_RXFULL]) begin
					r_next.rxfull = 1'b0;
				end
			end else if (avs_address == OFS_RXMASK) begin
				r_next.rxmask = merge(r_reg.rxmask, avs_writedata, avs_byteenable);
			end else if (avs_address == OFS_RXID) begin
				r_next.rxid = merge(r_reg.rxid, avs_writedata, avs_byteenable);
			end else if (avs_address == OFS_INTERRUPT_MASK_REGISTER) begin
				r_next.interrupt_mask_register = merge(r_reg.interrupt_mask_register, avs_writedata, avs_byteenable);
			end else if ((avs_address >= OFS_QUEUE) && (avs_address <= OFS_QEND)
					&& (avs_address[1:0] == 2'h0) && avs_byteenable[0]) begin
				// software refills either half while the other is shifting
				// entries written without lane 0 stay as they were
				r_next.queue[avs_address[5:2]] = avs_writedata[7:0];
			end
		end

		// receive buffer: a fresh frame overwrites the previous one
		// the handler must empty it before the next frame or lose the older one
		if (hit) begin
			r_next.rxbuf = hit_data;
			r_next.rxfull = 1'b1;
		end

		// queue sequencer, the only master of the DAC link
		case (r_reg.state)
			QSD_IDLE: begin
				// a run always starts at entry 0
				if (r_reg.run) begin
					r_next.ptr = 4'h0;
					r_next.cnt = pre_load(r_reg.pre);
					r_next.state = QSD_PRE;
				end
			end
			QSD_PRE: begin
				if (r_reg.cnt == 13'h0000) begin
					r_next.cnt = {7'h00, SHIFT_LAST};
					// channel follows entry parity: even entries go left, odd entries right
					r_next.right = r_reg.ptr[0];
					r_next.state = QSD_SHIFT;
				end else begin
					r_next.cnt = r_reg.cnt - 13'h0001;
				end
			end
			QSD_SHIFT: begin
				if (r_reg.cnt == 13'h0000) begin
					r_next.cnt = post_load(r_reg.post);
					r_next.state = QSD_POST;
				end else begin
					r_next.cnt = r_reg.cnt - 13'h0001;
				end
			end
			QSD_POST: begin
				if (r_reg.cnt != 13'h0000) begin
					r_next.cnt = r_reg.cnt - 13'h0001;
				end else begin
					// pointer shows the last entry whose post delay is over
					r_next.cptr = r_reg.ptr;
					r_next.cnt = pre_load(r_reg.pre);
					if (r_reg.ptr != QUEUE_LAST) begin
						r_next.ptr = r_reg.ptr + 4'h1;
						r_next.state = QSD_PRE;
					end else begin
						r_next.fin = 1'b1;
						r_next.ptr = 4'h0;
						if (r_reg.wrap && r_reg.run) begin
							// entry 0 goes out next, refreshed or not
							r_next.state = QSD_PRE;
						end else begin
							r_next.run = 1'b0;
							r_next.state = QSD_IDLE;
						end
					end
				end
			end
			default: begin
				r_next.state = QSD_IDLE;
			end
		endcase

		// only the finished and rx full flags reach an interrupt; pointer 7 is polled
		r_next.fin_irq = r_next.fin & r_next.fin_ie;
		r_next.rx_irq = r_next.rxfull & r_next.interrupt_mask_register[INTERRUPT_MASK_REGISTER_RX6];
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			// fields not named below clear to zero
			r_reg <= '0;
			r_reg.wait_q <= 1'b1;
			r_reg.pre <= RST_PRE;
			r_reg.post <= RST_POST;
			r_reg.rxmask <= RST_RXMASK;
			r_reg.rxid <= RST_RXID;
			r_reg.state <= QSD_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata = r_reg.rdata;
	assign avs_waitrequest = r_reg.wait_q;
	assign dac_right = r_reg.right;
	assign finished_irq = r_reg.fin_irq;
	assign rx_irq = r_reg.rx_irq;

endmodule

// file: qsd_audio_out_assertions.sv
`timescale 1ns/1ps
module qsd_audio_out_checker
	import qsd_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic avs_write,
	input wire logic can_frame_valid,
	input wire logic dac_sck,
	input wire logic dac_mosi,
	input wire logic dac_cs_n,
	input wire logic finished_irq,
	input wire logic rx_irq
);
	logic [6:0] cs_cnt_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// cycles spent inside the current word, held one cycle after deselect, then zero
	always_ff @(posedge clock)
		if (!rst_n || dac_cs_n) cs_cnt_reg <= 7'h00;
		else cs_cnt_reg <= cs_cnt_reg + 7'h01;

	////////////////////////////////////////////////////////////////////////
	property p_sck_idle; dac_cs_n |-> !dac_sck; endproperty
	a_sck_idle: assert property (p_sck_idle)
		else $error("serial clock moves outside a word");
	property p_sck_div; $rose(dac_sck) |=> dac_sck ##1 !dac_sck ##1 !dac_sck; endproperty
	a_sck_div: assert property (p_sck_div)
		else $error("serial clock not a quarter of the system clock");
	property p_word_len; $rose(dac_cs_n) |-> cs_cnt_reg == 7'h40; endproperty
	a_word_len: assert property (p_word_len)
		else $error("word select not 64 cycles long");
	property p_low_zero; !dac_cs_n && cs_cnt_reg >= 7'h20 |-> !dac_mosi; endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low byte of word not zero");
	property p_mosi_hold; dac_sck |-> $stable(dac_mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold)
		else $error("data changed while serial clock high");
	property p_post_gap; $rose(dac_cs_n) |-> dac_cs_n[*8]; endproperty
	a_post_gap: assert property (p_post_gap)
		else $error("post delay too short");
	property p_fin_irq; $rose(finished_irq) |-> dac_cs_n; endproperty
	a_fin_irq: assert property (p_fin_irq)
		else $error("finished interrupt raised inside a word");
	property p_rx_irq;
		$rose(rx_irq) |-> $past(can_frame_valid, 2) || $past(avs_write) || $past(avs_write, 2);
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("receive interrupt without a frame");
endmodule

bind qsd_audio_out qsd_audio_out_checker u_qsd_audio_out_checker (.clock, .rst_n, .avs_write,
	.can_frame_valid, .dac_sck, .dac_mosi, .dac_cs_n, .finished_irq, .rx_irq);

// file: qsd_dac_model.sv
`timescale 1ns/1ps
module qsd_dac_model
	import qsd_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  dac_sck,
	input  wire logic  dac_mosi,
	input  wire logic  dac_cs_n,
	input  wire logic  dac_right,
	output logic [15:0] word_q,
	output logic       chan_q,
	output int         words,
	output int         period,
	output int         bits
);
	logic [15:0] sh;
	logic        cs_d;
	int          nb;
	int          cnt;

	initial begin
		{word_q, chan_q, sh, cs_d} = '0;
		{words, period, bits, nb, cnt} = '0;
	end

	// clocks from one word select to the next
	always @(posedge clock) begin
		cnt <= cnt + 1;
		cs_d <= dac_cs_n;
		if (!dac_cs_n && cs_d) begin
			period <= cnt;
			cnt <= 1;
			// channel is taken one edge after select falls, once both have settled
			chan_q <= dac_right;
		end
	end

	// converter takes data on the rising serial clock, first bit is the top bit
	always @(posedge dac_sck) if (!dac_cs_n) begin
		sh <= {sh[14:0], dac_mosi};
		nb <= nb + 1;
	end

	// nb guards the select edge that reset produces
	always @(posedge dac_cs_n) if (nb != 0) begin
		word_q <= sh;
		bits <= nb;
		nb <= 0;
		words <= words + 1;
	end
endmodule

// file: tb_qsd_audio_out.sv
`timescale 1ns/1ps
module tb_qsd_audio_out
	import qsd_pkg::*;
;
	logic        clock, rst_n, avs_read, avs_write, can_frame_valid, chan_q;
	logic        avs_waitrequest, dac_sck, dac_mosi, dac_cs_n, dac_right, finished_irq, rx_irq;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, can_frame_id, rd_v;
	logic [63:0] can_frame_data;
	logic [15:0] word_q;
	int          words, period, bits, miscompares, n_compared, cyc, w0;

	qsd_audio_out u_qsd_audio_out (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
		.can_frame_valid, .can_frame_id, .can_frame_data, .dac_sck, .dac_mosi, .dac_cs_n,
		.dac_right, .finished_irq, .rx_irq);
	qsd_dac_model u_qsd_dac_model (.clock, .dac_sck, .dac_mosi, .dac_cs_n, .dac_right,
		.word_q, .chan_q, .words, .period, .bits);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// runs far past the longest expected sequence
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task nxt;
		w0 = words;
		while (words == w0) @(posedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, avs_read, avs_write, can_frame_valid, avs_address} = '0;
		{avs_writedata, can_frame_id, can_frame_data} = '0;
		{miscompares, n_compared, cyc} = '0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd(OFS_DELAY, rd_v);
		chk("delay", rd_v, 32'h00000816);
		rd(OFS_RXMASK, rd_v);
		chk("rxmask", rd_v, 32'h0FF0FFFE);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20, rd_v);
		chk("unmapped", rd_v, 32'h00000000);
		for (int i = 0; i < 16; i++) wr(OFS_QUEUE + 8'(4 * i), 32'(i * 17));
		wr(OFS_CTRL, 32'h00000007);
		// seventeenth word comes from the untouched queue start
		for (int i = 0; i < 17; i++) begin
			nxt();
			chk("word", word_q, {8'((i % 16) * 17), 8'h00});
			chk("chan", chan_q, i % 2);
			chk("bits", bits, 16);
			if (i > 0) chk("period", period, 342);
			if (i == 8) begin
				rd(OFS_STATUS, rd_v);
				chk("midptr", rd_v[7:4], 7);
			end
		end
		rd(OFS_STATUS, rd_v);
		chk("finished", rd_v & 32'hF1, 32'hF1);
		chk("finirq", finished_irq, 1);
		wr(OFS_STATUS, 32'h00000001);
		repeat (2) @(posedge clock);
		chk("finclr", finished_irq, 0);
		wr(OFS_QEND, 32'h000000C3);
		rd(OFS_QEND, rd_v);
		chk("refill", rd_v, 32'h000000C3);
		// new delays apply from the word after the one in flight
		for (int k = 0; k < 2; k++) begin
			nxt();
			wr(OFS_DELAY, k ? 32'h0000007F : 32'h00000101);
			nxt();
			nxt();
			chk("period", period, k ? 8383 : 97);
		end
		wr(OFS_INTERRUPT_MASK_REGISTER, 32'h00000040);
		for (int k = 0; k < 6; k++) begin
			@(posedge clock);
			can_frame_valid <= 1'b1;
			// audio ids differ only in bits that the mask ignores
			can_frame_id <= (k < 5) ? 32'(k) << 16 : 32'h00200000;
			can_frame_data <= {32'hA5A5A500 + 32'(k), 32'h5A5A5A00 + 32'(k)};
			@(posedge clock);
			can_frame_valid <= 1'b0;
			repeat (4) @(posedge clock);
			chk("rxirq", rx_irq, k < 5);
			rd(OFS_RXLO, rd_v);
			chk("rxlo", rd_v, 32'h5A5A5A00 + 32'((k < 5) ? k : 4));
			rd(OFS_RXHI, rd_v);
			chk("rxhi", rd_v, 32'hA5A5A500 + 32'((k < 5) ? k : 4));
			wr(OFS_STATUS, 32'h00000100);
		end
		finish_test();
	end
endmodule
